// File: pfw_writer.sv
`timescale 1ns/1ps
`default_nettype none

module pfw_writer import pfw_pkg::*; #(
   parameter int LATCHES = LATCHES_DFLT,
   parameter int ROW_WORDS = ROW_WORDS_DFLT,
   parameter int ERASE_CYCLES = ERASE_CYCLES_DFLT,
   parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // control bits
   input wire pfw_ctrl_s ctrl,
   // address and data register pairs
   input wire logic [ADDR_HI_W-1:0] nvm_address_high,
   input wire logic [7:0] nvm_address_low,
   input wire logic [DATA_HI_W-1:0] nvm_data_high,
   input wire logic [7:0] nvm_data_low,
   // unlock port write and start bit set
   input wire logic unlock_wr,
   input wire logic [7:0] unlock_wdata,
   input wire logic start_set,
   // status
   output logic start_bit,
   output logic erase_busy,
   output logic cpu_stall,
   // flash array command
   output pfw_flash_s flash
);
   localparam int IDX_W = $clog2(LATCHES);
   localparam int ROW_W = $clog2(ROW_WORDS);
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(LATCHES - 1);

   // ==========================================================
   // reset release
   logic [1:0] rst_sync_q;
   logic rst_n_i;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n_i = rst_sync_q[1];

   // ==========================================================
   // unlock tracker
   // any stray unlock write or start write throws the arming away
   logic [1:0] unl_q, unl_d;
   logic armed, accept;
   pfw_op_e op_q, op_d;
   pfw_state_e state_q, state_d;

   assign armed = (unl_q == 2'h2);
   assign accept = start_set && armed && (state_q == ST_IDLE) && ctrl.write_allow
      && ctrl.program_space_select && !ctrl.configuration_space_select; // R6 R18

   always_comb begin
      unl_d = unl_q;
      if (start_set) unl_d = 2'h0; // R18
      else if (unlock_wr) begin
         if (unlock_wdata == UNLOCK_FIRST) unl_d = 2'h1;
         else if (unlock_wdata == UNLOCK_SECOND && unl_q == 2'h1) unl_d = 2'h2; // R6
         else unl_d = 2'h0;
      end
   end

   // ==========================================================
   // operation select and snapshot of the register pairs
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic [ADDR_W-1:0] addr_in;

   assign addr_in = {nvm_address_high, nvm_address_low};
   assign op_d = ctrl.row_erase_select ? OP_ERASE : // R16
      (ctrl.latch_only_mode ? OP_LATCH : OP_PROG); // R8 R9

   // snapshot means software may reload the pairs while we stall
   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unl_q <= 2'h0;
         op_q <= OP_LATCH;
         addr_q <= '0;
         data_q <= '0;
      end else begin
         unl_q <= unl_d;
         if (accept) begin
            op_q <= op_d;
            addr_q <= addr_in;
            data_q <= {nvm_data_high, nvm_data_low};
         end
      end
   end

   // ==========================================================
   // sequencer
   logic [IDX_W-1:0] idx_q, idx_d;
   logic [31:0] tmr_q, tmr_d;
   logic tmr_zero;

   assign tmr_zero = (tmr_q == 32'h0);

   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      tmr_d = tmr_zero ? tmr_q : tmr_q - 32'h1;
      unique case (state_q)
         ST_IDLE: if (accept) state_d = ST_SETUP1;
         ST_SETUP1: state_d = ST_SETUP2; // R15
         ST_SETUP2: begin
            if (op_q == OP_ERASE) begin
               state_d = ST_ERASE;
               tmr_d = 32'(ERASE_CYCLES);
            end else state_d = ST_LOAD;
         end
         ST_LOAD: begin
            idx_d = '0;
            state_d = (op_q == OP_PROG) ? ST_PROG : ST_DONE; // R8 R9
         end
         ST_PROG: begin
            idx_d = idx_q + IDX_W'(1);
            if (idx_q == LAST_IDX) begin // R3 R10
               state_d = ST_WAIT;
               tmr_d = 32'(PROG_CYCLES);
            end
         end
         ST_WAIT: if (tmr_zero) state_d = ST_DONE;
         ST_ERASE: if (tmr_zero) state_d = ST_DONE;
         ST_DONE: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         idx_q <= '0;
         tmr_q <= 32'h0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         tmr_q <= tmr_d;
      end
   end

   // ==========================================================
   // latch bank
   logic lt_we, lt_clear;
   logic [DATA_W-1:0] lt_rd;

   assign lt_we = (state_q == ST_LOAD);
   assign lt_clear = (state_q == ST_DONE) && (op_q == OP_PROG); // R5

   pfw_latch_bank #(.LATCHES(LATCHES)) u_latch (
      .clk(mclk),
      .rst_n(rst_n_i),
      .wr_en(lt_we),
      .wr_idx(addr_q[IDX_W-1:0]),
      .wr_data(data_q),
      .clear_all(lt_clear),
      .rd_idx(idx_q),
      .rd_data(lt_rd)
   );

   // ==========================================================
   // flash command and status outputs
   pfw_flash_s flash_d;
   logic stall_d, start_d, erase_busy_d;

   // write never carries an erase; erase address is row aligned
   always_comb begin
      flash_d = '0;
      if (state_q == ST_PROG) begin
         flash_d.we = 1'b1; // R1 R10
         flash_d.addr = {addr_q[ADDR_W-1:IDX_W], idx_q}; // R4
         flash_d.data = lt_rd;
      end else if (state_q == ST_SETUP2 && op_q == OP_ERASE) begin
         flash_d.erase = 1'b1; // R2
         flash_d.addr = {addr_q[ADDR_W-1:ROW_W], ROW_W'(0)}; // R2
      end
   end

   assign stall_d = (state_d == ST_LOAD) || (state_d == ST_PROG) || (state_d == ST_WAIT)
      || (state_d == ST_ERASE) || (state_d == ST_DONE); // R15
   assign start_d = accept || (start_bit && state_q != ST_DONE); // R17
   assign erase_busy_d = (accept && op_d == OP_ERASE)
      || (erase_busy && state_q != ST_DONE); // R16

   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flash <= '0;
         cpu_stall <= 1'b0;
         start_bit <= 1'b0;
         erase_busy <= 1'b0;
      end else begin
         flash <= flash_d;
         cpu_stall <= stall_d;
         start_bit <= start_d;
         erase_busy <= erase_busy_d;
      end
   end

   // ==========================================================
   // checks
   int unsigned we_cnt;
   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) we_cnt <= 0;
      else if (accept) we_cnt <= 0;
      else if (flash.we) we_cnt <= we_cnt + 1;
   end

   chk_write_no_erase: assert property (@(posedge mclk) disable iff (!rst_n_i) // R1
      flash.we |-> !flash.erase && op_q == OP_PROG)
      else $error("erase seen during write");
   chk_erase_row_align: assert property (@(posedge mclk) disable iff (!rst_n_i) // R2
      flash.erase |-> flash.addr[ROW_W-1:0] == '0 && $past(state_q) == ST_SETUP2)
      else $error("erase not row aligned");
   chk_word_count: assert property (@(posedge mclk) disable iff (!rst_n_i) // R3
      we_cnt <= LATCHES)
      else $error("too many words in one operation");
   chk_block_stay: assert property (@(posedge mclk) disable iff (!rst_n_i) // R4
      (flash.we && $past(flash.we)) |->
      flash.addr[ADDR_W-1:IDX_W] == $past(flash.addr[ADDR_W-1:IDX_W]))
      else $error("write crossed block boundary");
   chk_unlock_gate: assert property (@(posedge mclk) disable iff (!rst_n_i) // R6 R18
      $rose(start_bit) |-> $past(unl_q) == 2'h2 && $past(start_set))
      else $error("start taken without unlock");
   chk_latch_only: assert property (@(posedge mclk) disable iff (!rst_n_i) // R8
      (accept && op_d == OP_LATCH) |-> ##1 (!flash.we && !flash.erase) [*6])
      else $error("latch-only load touched flash");
   chk_full_block: assert property (@(posedge mclk) disable iff (!rst_n_i) // R9 R10
      $rose(flash.we) |-> flash.we [*8] ##1 !flash.we)
      else $error("block write not complete");
   chk_setup_two: assert property (@(posedge mclk) disable iff (!rst_n_i) // R15
      accept |=> !cpu_stall ##1 !cpu_stall ##1 cpu_stall)
      else $error("stall not after two setup cycles");
   chk_erase_hold: assert property (@(posedge mclk) disable iff (!rst_n_i) // R16
      (erase_busy && state_q != ST_DONE) |=> erase_busy && start_bit)
      else $error("erase readback dropped early");
   chk_start_clear: assert property (@(posedge mclk) disable iff (!rst_n_i) // R17
      $fell(start_bit) |-> $past(state_q) == ST_DONE && !cpu_stall)
      else $error("start bit cleared at wrong time");

   cov_latch_load: cover property (@(posedge mclk) disable iff (!rst_n_i)
      accept && op_d == OP_LATCH);
   cov_block_prog: cover property (@(posedge mclk) disable iff (!rst_n_i)
      lt_clear);
   cov_row_erase: cover property (@(posedge mclk) disable iff (!rst_n_i)
      flash.erase);
   cov_start_refused: cover property (@(posedge mclk) disable iff (!rst_n_i)
      start_set && !armed);
endmodule

`default_nettype wire

// File: pfw_pkg.sv
// Summary of operation
// (R1) writing never erases target words first
// (R2) erase acts on one whole row only
// (R3) one operation writes at most latch-count words
// (R4) latch block aligned, never spans two blocks
// (R5) latches return to 3FFF after programming
// (R6) 55h, AAh, then start bit gates action
// (R7) software keeps unlock sequence uninterrupted
// (R8) latch-only mode loads latch, no programming
// (R9) normal mode loads last latch, programs block
// (R10) programming always writes the complete block
// (R11) software sets mode bits before loading
// (R12) software sets address and data first
// (R13) software increments address between loads
// (R14) software repeats block writes per row
// (R15) two setup cycles, then stall till done
// (R16) row erase when erase select set
// (R17) start bit clears itself when finished
// (R18) start without fresh unlock is ignored
`timescale 1ns/1ps
`default_nettype none

package pfw_pkg;
   // ==========================================================
   // widths and values
   localparam int ADDR_W = 15;
   localparam int DATA_W = 14;
   localparam int ADDR_HI_W = 7;
   localparam int DATA_HI_W = 6;
   localparam logic [DATA_W-1:0] LATCH_RESET = 14'h3FFF;
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
   localparam int LATCHES_DFLT = 8;
   localparam int ROW_WORDS_DFLT = 32;
   // ==========================================================
   // timing
   localparam int CLK_MHZ = 200;
   localparam int ERASE_TIME_US = 2000;
   localparam int PROG_TIME_US = 2000;
   localparam int ERASE_CYCLES_DFLT = ERASE_TIME_US * CLK_MHZ;
   localparam int PROG_CYCLES_DFLT = PROG_TIME_US * CLK_MHZ;
   // ==========================================================
   // types
   typedef struct packed {
      logic program_space_select;
      logic write_allow;
      logic configuration_space_select;
      logic latch_only_mode;
      logic row_erase_select;
   } pfw_ctrl_s;

   typedef struct packed {
      logic we;
      logic erase;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pfw_flash_s;

   typedef enum logic [1:0] {
      OP_LATCH = 2'h0,
      OP_PROG = 2'h1,
      OP_ERASE = 2'h2
   } pfw_op_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP1 = 3'h1,
      ST_SETUP2 = 3'h3,
      ST_LOAD = 3'h2,
      ST_PROG = 3'h6,
      ST_WAIT = 3'h7,
      ST_ERASE = 3'h5,
      ST_DONE = 3'h4
   } pfw_state_e;
endpackage

// ==========================================================
// write latch bank
module pfw_latch_bank import pfw_pkg::*; #(
   parameter int LATCHES = LATCHES_DFLT,
   parameter int IDX_W = $clog2(LATCHES)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write side
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic clear_all,
   // read side
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem_q [LATCHES];

   // clear wins: a finished block leaves every latch blank
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LATCHES; i++) mem_q[i] <= LATCH_RESET;
      end else if (clear_all) begin
         for (int i = 0; i < LATCHES; i++) mem_q[i] <= LATCH_RESET; // R5
      end else if (wr_en) begin
         mem_q[wr_idx] <= wr_data;
      end
   end

   assign rd_data = mem_q[rd_idx];

   chk_latch_blank: assert property (@(posedge clk) disable iff (!rst_n) // R5
      clear_all |=> (mem_q[0] == LATCH_RESET && mem_q[LATCHES-1] == LATCH_RESET))
      else $error("latches not blank after block write");
endmodule

`default_nettype wire

// File: pfw_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: pfw_writer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pfw_writer_bench import pfw_pkg::*; ;
   // ==========================================================
   // stimulus and observation
   localparam int PC = 20;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   pfw_ctrl_s ctrl = '0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdat = '0;
   logic unlock_wr = 1'b0;
   logic [7:0] unlock_wdata = 8'h00;
   logic start_set = 1'b0;
   logic start_bit;
   logic erase_busy;
   logic cpu_stall;
   pfw_flash_s flash;
   int mismatches = 0;
   int n_tests = 0;
   logic [DATA_W-1:0] model [8];
   logic [31:0] beats [$];
   logic [31:0] erases [$];
   logic [4:0] bad_ctrl [3] = '{5'h12, 5'h0A, 5'h1E};

   always #2.5 mclk = ~mclk;

   // short counts keep the run small; the walk is the same
   pfw_writer #(.ERASE_CYCLES(PC), .PROG_CYCLES(PC)) pfw_writer_inst (
      .mclk(mclk),
      .rst_n(rst_n),
      .ctrl(ctrl),
      .nvm_address_high(addr[14:8]),
      .nvm_address_low(addr[7:0]),
      .nvm_data_high(wdat[13:8]),
      .nvm_data_low(wdat[7:0]),
      .unlock_wr(unlock_wr),
      .unlock_wdata(unlock_wdata),
      .start_set(start_set),
      .start_bit(start_bit),
      .erase_busy(erase_busy),
      .cpu_stall(cpu_stall),
      .flash(flash)
   );

   // collect every flash write beat and erase pulse in order;
   // falling edge, so the registered command has settled
   always @(negedge mclk) begin
      if (flash.we === 1'b1) beats.push_back(32'({flash.addr, flash.data}));
      if (flash.erase === 1'b1) erases.push_back(32'(flash.addr));
   end

   // ==========================================================
   // compare and closing
   task automatic check(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic finish_test();
      if (mismatches == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // unlock pair, start, then follow the operation to its end;
   // stall must hold off for the two setup cycles
   task automatic run(logic [4:0] c, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
                      logic [7:0] k1, logic [7:0] k2, logic go);
      int i;
      beats.delete();
      erases.delete();
      @(negedge mclk);
      ctrl = c;
      addr = a;
      wdat = d;
      unlock_wr = 1'b1;
      unlock_wdata = k1;
      @(negedge mclk);
      unlock_wdata = k2;
      @(negedge mclk);
      unlock_wr = 1'b0;
      start_set = 1'b1;
      @(negedge mclk);
      start_set = 1'b0;
      check("stall_setup1", 32'(0), 32'(cpu_stall));
      @(negedge mclk);
      check("stall_setup2", 32'(0), 32'(cpu_stall));
      check("start_bit", 32'(go), 32'(start_bit));
      check("erase_busy", 32'(go & c[0]), 32'(erase_busy));
      repeat (2) @(negedge mclk);
      check("stall_run", 32'(go), 32'(cpu_stall));
      i = 0;
      while (start_bit !== 1'b0 && i < PC + 60) begin
         @(negedge mclk);
         i++;
      end
      if (i == PC + 60) begin
         mismatches++;
         finish_test();
      end
      check("stall_end", 32'(0), 32'(cpu_stall));
      check("busy_end", 32'(0), 32'(erase_busy));
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [ADDR_W-1:0] base;
      logic [DATA_W-1:0] d;
      int idx;
      void'($urandom(4649));
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
      check("idle_start", 32'(0), 32'(start_bit));
      check("idle_flash", 32'(0), 32'(flash));
      for (int i = 0; i < 8; i++) model[i] = LATCH_RESET;
      // refused: no unlock, swapped keys, then each bad control setting
      run(5'h1A, '0, '0, 8'h00, 8'h00, 1'b0);
      run(5'h18, '0, '0, UNLOCK_SECOND, UNLOCK_FIRST, 1'b0);
      for (int j = 0; j < 3; j++) begin
         run(bad_ctrl[j], '0, '0, UNLOCK_FIRST, UNLOCK_SECOND, 1'b0);
         check("refused_beats", 32'(0), 32'(beats.size()));
      end
      // round 0 leaves latch 0 unloaded; later rounds load one latch at a random index
      for (int r = 0; r < 3; r++) begin
         base = ADDR_W'($urandom) & 15'h7FF8;
         for (int i = 1; i < 7 && r == 0; i++) begin
            d = DATA_W'($urandom);
            run(5'h1A, base | ADDR_W'(i), d, UNLOCK_FIRST, UNLOCK_SECOND, 1'b1);
            model[i] = d;
            check("latch_beats", 32'(0), 32'(beats.size()));
         end
         idx = (r == 0) ? 7 : int'($urandom % 8);
         d = DATA_W'($urandom);
         run(5'h18, base | ADDR_W'(idx), d, UNLOCK_FIRST, UNLOCK_SECOND, 1'b1);
         model[idx] = d;
         check("beat_count", 32'(8), 32'(beats.size()));
         for (int i = 0; i < 8; i++) begin
            check("beat", 32'({base | ADDR_W'(i), model[i]}), beats[i]);
            model[i] = LATCH_RESET;
         end
      end
      // row erase with latch-only also set: erase wins, nothing written
      base = ADDR_W'($urandom);
      run(5'h1B, base, '0, UNLOCK_FIRST, UNLOCK_SECOND, 1'b1);
      check("erase_count", 32'(1), 32'(erases.size()));
      check("erase_row", 32'(base & 15'h7FE0), erases[0]);
      check("erase_beats", 32'(0), 32'(beats.size()));
      finish_test();
   end
endmodule

`default_nettype wire
